// >>> rtl/ear_pkg.sv
package ear_pkg;

  // =====================================================================
  // Resource identifiers and defining values.
  // =====================================================================
  localparam logic [9:0]  RES_WARN      = 10'h107;
  localparam logic [9:0]  RES_FACRST    = 10'h108;
  localparam logic [9:0]  RES_ENCIDX    = 10'h109;
  localparam logic [9:0]  RES_POSFLT    = 10'h10A;
  localparam logic [9:0]  RES_SWRESET   = 10'h100;
  localparam logic [9:0]  RES_EXTIDX    = 10'h111;
  localparam logic [7:0]  SIZE_FACRST   = 8'h08;
  localparam logic [7:0]  SIZE_ENCIDX   = 8'h02;
  localparam logic [7:0]  SIZE_POSFLT   = 8'h04;
  localparam logic [7:0]  SIZE_EXTIDX   = 8'h02;
  localparam logic [7:0]  WLVL_FACRST   = 8'h02;
  localparam logic [7:0]  WLVL_ENCIDX   = 8'h03;
  localparam logic [7:0]  WLVL_POSFLT   = 8'h03;
  localparam logic [7:0]  RLVL_FACRST   = 8'h0F;
  localparam logic [7:0]  RLVL_OPEN     = 8'h00;

  // =====================================================================
  // Code words, ranges and field positions.
  // =====================================================================
  // The first character of a code word sits in data byte 0, the lowest byte.
  localparam logic [63:0] USER_FILES_RESET_WORD   = 64'h5346_5554_4553_4552;
  localparam logic [63:0] FULL_FACTORY_RESET_WORD = 64'h4C4C_4154_4553_4552;
  localparam logic [15:0] INDEX_MAX       = 16'h000F;
  localparam logic [15:0] INCORP_ENABLE   = 16'h000F;
  localparam logic [31:0] FILT_MIN        = 32'h0000_0BB8;
  localparam logic [31:0] FILT_MAX        = 32'h0000_927C;
  localparam logic [31:0] FILT_DEFAULT    = 32'h0000_88B8;
  localparam int          WTYPE_HI        = 7;
  localparam int          WTYPE_LO        = 5;
  localparam int          WFMT_HI         = 4;
  localparam int          WFMT_LO         = 2;
  localparam logic [4:0]  WARN_THR_BASE   = 5'h10;
  localparam int          NUM_WARN        = 16;

  // Warning type codes.
  localparam logic [2:0]  WT_BELOW = 3'h1;
  localparam logic [2:0]  WT_ABOVE = 3'h2;
  localparam logic [2:0]  WT_CLR   = 3'h3;
  localparam logic [2:0]  WT_SET   = 3'h4;

  // Evaluation period of the warnings: one second at 100 MHz.
  localparam int          EVAL_PERIOD_MS  = 1000;
  localparam int          CLK_MHZ         = 100;
  localparam int          EVAL_CYCLES     = EVAL_PERIOD_MS * 1000 * CLK_MHZ;

  // Long-message control byte.
  localparam logic [7:0]  CTRL_START      = 8'h01;

  // Error codes returned in the status.
  localparam logic [7:0]  ERR_NONE   = 8'h00;
  localparam logic [7:0]  ERR_RANGE  = 8'h01;
  localparam logic [7:0]  ERR_NOREAD = 8'h02;
  localparam logic [7:0]  ERR_OFFSET = 8'h03;
  localparam logic [7:0]  ERR_RID    = 8'h04;

  // Host register map.
  localparam logic [4:0]  HR_DATA0   = 5'h00;
  localparam logic [4:0]  HR_ADDR_H  = 5'h08;
  localparam logic [4:0]  HR_ADDR_L  = 5'h09;
  localparam logic [4:0]  HR_OFF_H   = 5'h0A;
  localparam logic [4:0]  HR_OFF_L   = 5'h0B;
  localparam logic [4:0]  HR_CTRL    = 5'h0C;
  localparam logic [4:0]  HR_STATUS  = 5'h0D;
  localparam logic [4:0]  HR_ERROR   = 5'h0E;
  localparam logic [4:0]  HR_IDENT   = 5'h0F;

  typedef logic [7:0] ear_byte_t;

  // Signed or unsigned compare of a value against a threshold in a given format.
  function automatic logic ear_less(input logic [63:0] a, input logic [63:0] b,
                                    input logic [2:0] fmt);
    logic [63:0] x;
    logic [63:0] y;
    x = a;
    y = b;
    unique case (fmt[1:0])
      2'd1:    begin x = {48'h0, a[15:0]} ^ {48'h0, fmt[2], 15'h0};
                     y = {48'h0, b[15:0]} ^ {48'h0, fmt[2], 15'h0}; end
      2'd2:    begin x = {32'h0, a[31:0]} ^ {32'h0, fmt[2], 31'h0};
                     y = {32'h0, b[31:0]} ^ {32'h0, fmt[2], 31'h0}; end
      2'd3:    begin x = a ^ {fmt[2], 63'h0};
                     y = b ^ {fmt[2], 63'h0}; end
      default: begin x = 64'h0; y = 64'h0; end
    endcase
    return x < y;
  endfunction

endpackage

// >>> rtl/ear_if.sv
`timescale 1ns/1ps
// Long-message channel between the drive-side master and the encoder.
interface ear_if;
  logic        req;        // One-cycle start pulse.
  logic        wr;         // Write when high, read when low.
  logic [9:0]  res_id;
  logic [15:0] offset;
  logic        ofs_mode;   // Defining-value read when high.
  logic [63:0] wdata;
  logic        done;       // One-cycle release pulse.
  logic        err;
  logic [7:0]  err_code;
  logic [63:0] rdata;

  modport host
  (
    output req, wr, res_id, offset, ofs_mode, wdata,
    input  done, err, err_code, rdata
  );
  modport dev
  (
    input  req, wr, res_id, offset, ofs_mode, wdata,
    output done, err, err_code, rdata
  );
endinterface

// >>> rtl/ear_warn_eval.sv
`timescale 1ns/1ps
// =====================================================================
// Evaluates one user warning against the monitored value.
// =====================================================================
module ear_warn_eval
  import ear_pkg::*;
(
  input  wire logic [7:0]  cfg,
  input  wire logic [63:0] thr,
  input  wire logic [63:0] value,
  input  wire logic [63:0] prev,
  output logic             hit
);
  logic [2:0] wtype;
  logic [2:0] wfmt;

  // Type and format fields of configuration byte 0.
  assign wtype = cfg[WTYPE_HI:WTYPE_LO];
  assign wfmt  = cfg[WFMT_HI:WFMT_LO];

  // Bit checks look at the masked bits that moved since the last evaluation.
  always_comb
  begin
    unique case (wtype)
      WT_BELOW: hit = (wfmt[1:0] != 2'd0) && ear_less(value, thr, wfmt);
      WT_ABOVE: hit = (wfmt[1:0] != 2'd0) && ear_less(thr, value, wfmt);
      WT_CLR:   hit = |(prev & ~value & thr);
      WT_SET:   hit = |(~prev & value & thr);
      default:  hit = 1'b0; // Off or reserved codes.
    endcase
  end
endmodule

// >>> rtl/ear_encoder.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
// Contract
// - Type field selects below, above, clear, set.
// - Format field picks 16/32/64 bit, signedness.
// - Offsets 00h-0Fh config, 10h-1Fh thresholds.
// - Warning reads return stored write layout.
// - Factory reset restores listed user settings.
// - Lifetime data and histogram stay untouched.
// - Only 8-byte code word triggers reset.
// - Factory-reset resource refuses reads.
// - Defining values 108h, size 8, level 2.
// - Index accepts 0-15, larger rejected.
// - Stored index reported at switch-on.
// - Index read returns stored value, default 0.
// - Defining values 109h, size 2, level 3.
// - Index change applies only after reset.
// - Filter 32-bit, 3000 to 37500 rpm, readable.
// - Defining values 10Ah, size 4, level 3.
// - Operator should keep filter default.
// - Operator avoids offset access there.
// - Extended resource offset 0 index, 1 enable.
// - Warnings evaluated each second, then reported.
// - Status 000Fh enables; defaults are zero.
module ear_encoder
  import ear_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  ear_if.dev               lm,
  input  wire logic [63:0] mon_value,
  output logic             warn_event,
  output logic [3:0]       enc_index,
  output logic             incorp_en,
  output logic             user_files_clear,
  output logic             log_clear
);
  // =====================================================================
  // State.
  // =====================================================================
  typedef struct packed {
    logic [NUM_WARN-1:0][31:0] cfg;  // Configuration bytes 3 to 0.
    logic [NUM_WARN-1:0][63:0] thr;
    logic [63:0] prev;
    logic [26:0] tick;
    logic        warn_ev;
    logic [3:0]  idx_store;     // Kept value, survives soft resets.
    logic [3:0]  idx_active;    // Value driven on enc_index, live after a reset.
    logic        inc_store;
    logic        inc_active;
    logic [31:0] filt;
    logic        done;
    logic        err;
    logic [7:0]  code;
    logic [63:0] rdata;
    logic        ufs_clr;
    logic        all_clr;
  } ear_dev_state_t;

  // Power-up contents: a never-written index and enable read as zero.
  ear_dev_state_t s_q = '0;
  ear_dev_state_t s_d;
  logic [NUM_WARN-1:0] hit;

  // One evaluator per user warning.
  for (genvar g = 0; g < NUM_WARN; g++)
  begin : g_warn
    ear_warn_eval u_eval
    (
      .cfg   (s_q.cfg[g][7:0]),
      .thr   (s_q.thr[g]),
      .value (mon_value),
      .prev  (s_q.prev),
      .hit   (hit[g])
    );
  end

  // =====================================================================
  // Command interpretation and warning timing.
  // =====================================================================
  // The persistent index is modelled as a flop that the system and software resets
  // leave intact, cleared only at power-up; real storage lives outside.
  always_comb
  begin
    logic [4:0] wsel;
    logic       applied;
    wsel    = lm.offset[4:0];
    applied = 1'b0;
    s_d          = s_q;
    s_d.done     = 1'b0;
    s_d.warn_ev  = 1'b0;
    s_d.ufs_clr  = 1'b0;
    s_d.all_clr  = 1'b0;
    // Once per second all warnings are checked.
    if (s_q.tick == 27'(EVAL_CYCLES - 1))
    begin
      s_d.tick      = 27'h0;
      s_d.prev      = mon_value;
      s_d.warn_ev   = |hit;
    end
    else
    begin
      s_d.tick = s_q.tick + 27'h1;
    end
    if (lm.req)
    begin
      s_d.done  = 1'b1;
      s_d.err   = 1'b0;
      s_d.code  = ERR_NONE;
      s_d.rdata = 64'h0;
      unique case (lm.res_id)
        RES_WARN:
        begin
          if (lm.offset > 16'h001F)
          begin
            s_d.err  = 1'b1;
            s_d.code = ERR_OFFSET;
          end
          else if (wsel < WARN_THR_BASE)
          begin
            if (lm.wr) s_d.cfg[wsel[3:0]] = lm.wdata[31:0];
            else       s_d.rdata = {32'h0, s_q.cfg[wsel[3:0]]};
          end
          else
          begin
            if (lm.wr) s_d.thr[wsel[3:0]] = lm.wdata;
            else       s_d.rdata = s_q.thr[wsel[3:0]];
          end
        end
        RES_FACRST:
        begin
          if (lm.ofs_mode)
          begin
            s_d.rdata = {32'h0, WLVL_FACRST, RLVL_FACRST, SIZE_FACRST, RES_FACRST[7:0]};
          end
          else if (!lm.wr)
          begin
            s_d.err  = 1'b1;
            s_d.code = ERR_NOREAD;
          end
          else if (lm.wdata == FULL_FACTORY_RESET_WORD)
          begin
            // Lifetime and histogram are not held here and stay put.
            s_d.cfg     = '0;
            s_d.thr     = '0;
            s_d.ufs_clr = 1'b1;
            s_d.all_clr = 1'b1;
          end
          else if (lm.wdata == USER_FILES_RESET_WORD)
          begin
            s_d.ufs_clr = 1'b1;
          end
          else
          begin
            s_d.err  = 1'b1;
            s_d.code = ERR_RANGE;
          end
        end
        RES_ENCIDX:
        begin
          if (lm.ofs_mode)
            s_d.rdata = {32'h0, WLVL_ENCIDX, RLVL_OPEN, SIZE_ENCIDX, RES_ENCIDX[7:0]};
          else if (!lm.wr)
            s_d.rdata = {60'h0, s_q.idx_store};
          else if (lm.wdata[15:0] > INDEX_MAX)
          begin
            s_d.err  = 1'b1;
            s_d.code = ERR_RANGE;
          end
          else
            s_d.idx_store = lm.wdata[3:0];
        end
        RES_POSFLT:
        begin
          if (lm.ofs_mode)
            s_d.rdata = {32'h0, WLVL_POSFLT, RLVL_OPEN, SIZE_POSFLT, RES_POSFLT[7:0]};
          else if (!lm.wr)
            s_d.rdata = {32'h0, s_q.filt};
          else if (lm.wdata[31:0] < FILT_MIN || lm.wdata[31:0] > FILT_MAX)
          begin
            s_d.err  = 1'b1;
            s_d.code = ERR_RANGE;
          end
          else
            s_d.filt = lm.wdata[31:0];
        end
        RES_EXTIDX:
        begin
          if (lm.offset == 16'h0000)
          begin
            if (!lm.wr)
              s_d.rdata = {60'h0, s_q.idx_store};
            else if (lm.wdata[15:0] > INDEX_MAX)
            begin
              s_d.err  = 1'b1;
              s_d.code = ERR_RANGE;
            end
            else
              s_d.idx_store = lm.wdata[3:0];
          end
          else if (lm.offset == 16'h0001)
          begin
            if (!lm.wr)
              s_d.rdata = {48'h0, s_q.inc_store ? INCORP_ENABLE : 16'h0000};
            else if (lm.wdata[15:0] > INCORP_ENABLE)
            begin
              s_d.err  = 1'b1;
              s_d.code = ERR_RANGE;
            end
            else
              s_d.inc_store = (lm.wdata[15:0] == INCORP_ENABLE);
          end
          else
          begin
            s_d.err  = 1'b1;
            s_d.code = ERR_OFFSET;
          end
        end
        RES_SWRESET:
        begin
          // Software reset makes the stored index live.
          applied = 1'b1;
        end
        default:
        begin
          s_d.err  = 1'b1;
          s_d.code = ERR_RID;
        end
      endcase
    end
    if (applied)
    begin
      s_d.idx_active = s_q.idx_store;
      s_d.inc_active = s_q.inc_store;
    end
  end

  // State register; defaults are zero index and disabled incorporation.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q            <= '0;
      s_q.idx_store  <= s_q.idx_store; // Persists through a hardware reset.
      s_q.inc_store  <= s_q.inc_store;
      s_q.idx_active <= s_q.idx_store;
      s_q.inc_active <= s_q.inc_store;
      s_q.filt       <= FILT_DEFAULT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lm.done          = s_q.done;
  assign lm.err           = s_q.err;
  assign lm.err_code      = s_q.code;
  assign lm.rdata         = s_q.rdata;
  assign warn_event       = s_q.warn_ev;
  assign enc_index        = s_q.idx_active;
  assign incorp_en        = s_q.inc_active;
  assign user_files_clear = s_q.ufs_clr;
  assign log_clear        = s_q.all_clr;
endmodule

// >>> rtl/ear_master.sv
`timescale 1ns/1ps
// =====================================================================
// Drive-side master: registers loaded by software, one message in flight.
// =====================================================================
module ear_master
  import ear_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  ear_if.host              lm,
  input  wire logic [4:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [7:0]       rdata
);
  typedef enum logic [0:0] {ST_IDLE, ST_BUSY} ear_mst_state_t;

  typedef struct packed {
    ear_mst_state_t    st;
    logic [7:0][7:0]   buf_b;
    logic [7:0]        addr_h;
    logic [7:0]        addr_l;
    logic [7:0]        off_h;
    logic [7:0]        off_l;
    logic              release_flag;
    logic              err;
    logic [7:0]        code;
    logic [7:0]        enc_ident;
    logic              req;
    logic [7:0]        rd;
  } ear_mst_t;

  ear_mst_t m_q;
  ear_mst_t m_d;

  // Software loads data and address, then starts with the control byte.
  always_comb
  begin
    m_d     = m_q;
    m_d.req = 1'b0;
    m_d.rd  = 8'h00;
    if (wr_stb && m_q.st == ST_IDLE)
    begin
      if (addr < HR_ADDR_H) m_d.buf_b[addr[2:0]] = wdata;
      else if (addr == HR_ADDR_H) m_d.addr_h = wdata;
      else if (addr == HR_ADDR_L) m_d.addr_l = wdata;
      else if (addr == HR_OFF_H)  m_d.off_h  = wdata;
      else if (addr == HR_OFF_L)  m_d.off_l  = wdata;
      else if (addr == HR_CTRL && wdata == CTRL_START)
      begin
        m_d.req          = 1'b1;
        m_d.release_flag = 1'b0;
        m_d.st           = ST_BUSY;
      end
    end
    if (rd_stb)
    begin
      if (addr < HR_ADDR_H)       m_d.rd = m_q.buf_b[addr[2:0]];
      else if (addr == HR_STATUS) m_d.rd = {6'h0, m_q.err, m_q.release_flag};
      else if (addr == HR_ERROR)  m_d.rd = m_q.code;
      else if (addr == HR_IDENT)  m_d.rd = m_q.enc_ident;
    end
    unique case (m_q.st)
      ST_IDLE: ;
      ST_BUSY:
      begin
        if (lm.done)
        begin
          m_d.st           = ST_IDLE;
          m_d.release_flag = 1'b1;
          m_d.err          = lm.err;
          m_d.code         = lm.err_code;
          if (!m_q.addr_h[7] && !lm.err) m_d.buf_b = lm.rdata;
          // Index read back fills the identification register.
          // Defining-value reads carry no index and are left out.
          if ({m_q.addr_h[1:0], m_q.addr_l} == RES_ENCIDX && !lm.err && m_q.addr_h[7:6] == 2'b00)
            m_d.enc_ident = lm.rdata[7:0];
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      m_q    <= '0;
      m_q.st <= ST_IDLE;
    end
    else
    begin
      m_q <= m_d;
    end
  end

  // Address high: bit 7 write, bit 6 offset mode, bits 1:0 upper identifier.
  assign lm.req      = m_q.req;
  assign lm.wr       = m_q.addr_h[7];
  assign lm.ofs_mode = m_q.addr_h[6];
  assign lm.res_id   = {m_q.addr_h[1:0], m_q.addr_l};
  assign lm.offset   = {m_q.off_h, m_q.off_l};
  assign lm.wdata    = m_q.buf_b;
  assign rdata       = m_q.rd;
endmodule

// >>> test/ear_checker.sv
`timescale 1ns/1ps
// =====================================================================
// Long-message channel checker, watching both ends on one interface.
// =====================================================================
module ear_checker
  import ear_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        req,
  input wire logic        wr,
  input wire logic [9:0]  res_id,
  input wire logic [15:0] offset,
  input wire logic        ofs_mode,
  input wire logic [63:0] wdata,
  input wire logic        done,
  input wire logic        err,
  input wire logic [7:0]  err_code,
  input wire logic [63:0] rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Plain accesses, as opposed to reads of the defining values.
  wire logic plain;
  wire logic filt_bad;
  assign plain    = req && !ofs_mode;
  assign filt_bad = (wdata[31:0] < FILT_MIN) || (wdata[31:0] > FILT_MAX);

  // =====================================================================
  // Handshake timing.
  // =====================================================================
  answer_time_a: assert property (req |=> done)
    else $error("No release one cycle after a request.");
  done_cause_a: assert property (done |-> $past(req))
    else $error("Release without a request.");
  done_pulse_a: assert property (done |=> !done)
    else $error("Release lasts more than one cycle.");
  rdata_hold_a: assert property (!done |-> $stable(rdata))
    else $error("Read data moved between answers.");

  // =====================================================================
  // Refusals, each but the filter range one with its exact error code.
  // =====================================================================
  fr_noread_a: assert property (plain && !wr && res_id == RES_FACRST
    |=> err && err_code == ERR_NOREAD) else $error("Factory reset read not refused.");
  idx_range_a: assert property (plain && wr && res_id == RES_ENCIDX
    && wdata[15:0] > INDEX_MAX |=> err && err_code == ERR_RANGE)
    else $error("Index above fifteen accepted.");
  filt_range_a: assert property (plain && wr && res_id == RES_POSFLT
    |=> err == $past(filt_bad)) else $error("Filter range check wrong.");
  warn_ofs_a: assert property (plain && res_id == RES_WARN && offset > 16'h001F
    |=> err && err_code == ERR_OFFSET) else $error("Warning offset not refused.");
  ext_ofs_a: assert property (plain && res_id == RES_EXTIDX && offset > 16'h0001
    |=> err && err_code == ERR_OFFSET) else $error("Extended offset not refused.");

  // =====================================================================
  // Defining values: write level, read level, size, identifier low byte.
  // =====================================================================
  def_fr_a: assert property (req && ofs_mode && res_id == RES_FACRST
    |=> rdata[31:0] == 32'h020F_0808) else $error("Factory reset defining values.");
  def_idx_a: assert property (req && ofs_mode && res_id == RES_ENCIDX
    |=> rdata[31:0] == 32'h0300_0209) else $error("Index defining values.");
  def_filt_a: assert property (req && ofs_mode && res_id == RES_POSFLT
    |=> rdata[31:0] == 32'h0300_040A) else $error("Filter defining values.");
endmodule

// >>> test/test_encoder_admin_resources.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
// =====================================================================
// Bench: software port of the master, encoder behind the channel.
// =====================================================================
module test_encoder_admin_resources
  import ear_pkg::*;
;
  logic        sys_clk;
  logic        rst;
  logic [4:0]  addr;
  logic [7:0]  wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [7:0]  rdata;
  logic [63:0] mon_value;
  logic        warn_event;
  logic [3:0]  enc_index;
  logic        incorp_en;
  logic        user_files_clear;
  logic        log_clear;
  logic [7:0]  rerr;
  logic [63:0] rd64;
  logic [63:0] m;
  int          errors;
  int          checks_done;
  int          cycles;
  int          ufc_n;
  int          lc_n;
  int          fmts[6] = '{1, 2, 3, 5, 6, 7};
  logic [31:0] fv[4] = '{32'd2999, 32'd3000, 32'd37501, 32'd37500};

  ear_if bus ();
  ear_master i_ear_master (.sys_clk(sys_clk), .rst(rst), .lm(bus), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata));
  ear_encoder i_ear_encoder (.sys_clk(sys_clk), .rst(rst), .lm(bus),
    .mon_value(mon_value), .warn_event(warn_event), .enc_index(enc_index),
    .incorp_en(incorp_en), .user_files_clear(user_files_clear), .log_clear(log_clear));
  ear_checker i_ear_checker (.sys_clk(sys_clk), .rst(rst), .req(bus.req), .wr(bus.wr),
    .res_id(bus.res_id), .offset(bus.offset), .ofs_mode(bus.ofs_mode), .wdata(bus.wdata),
    .done(bus.done), .err(bus.err), .err_code(bus.err_code), .rdata(bus.rdata));

  // Clock at 100 MHz.
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulse counters and a hang guard well above the expected run length.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (user_files_clear === 1'b1) ufc_n++;
    if (log_clear === 1'b1) lc_n++;
    if (cycles == 20000)
    begin
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One register write; strobe released on the edge that takes it.
  task automatic reg_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask

  // One register read; data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask

  // A whole long message: load, start, wait for release, collect results.
  task automatic acc(input logic w, input logic dfn, input logic [9:0] r,
                     input logic [15:0] ofs, input logic [63:0] d);
    logic [7:0] b;
    int         n;
    for (int i = 0; i < 8; i++) reg_wr(HR_DATA0 + 5'(i), d[8*i +: 8]);
    reg_wr(HR_ADDR_H, {w, dfn, 4'h0, r[9:8]});
    reg_wr(HR_ADDR_L, r[7:0]);
    reg_wr(HR_OFF_H, ofs[15:8]);
    reg_wr(HR_OFF_L, ofs[7:0]);
    reg_wr(HR_CTRL, CTRL_START);
    b = 8'h00;
    n = 0;
    while (b[0] !== 1'b1 && n < 40)
    begin
      reg_rd(HR_STATUS, b);
      n++;
    end
    if (n >= 40) `CHK(b[0], 1'b1)
    reg_rd(HR_ERROR, rerr);
    for (int i = 0; i < 8; i++) reg_rd(HR_DATA0 + 5'(i), rd64[8*i +: 8]);
  endtask

  // =====================================================================
  // Main sequence.
  // =====================================================================
  initial
  begin
    rst = 1'b1;
    addr = 5'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    mon_value = 64'h0000_0000_0000_0064;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    `CHK(enc_index, 4'h0)
    `CHK(incorp_en, 1'b0)
    // Index and filter are always reached whole, at offset zero.
    acc(1'b0, 1'b0, RES_ENCIDX, 16'h0000, 64'h0);
    `CHK(rd64[15:0], 16'h0000)
    acc(1'b0, 1'b1, RES_FACRST, 16'h0000, 64'h0);
    `CHK(rd64[31:0], 32'h020F_0808)
    acc(1'b0, 1'b1, RES_ENCIDX, 16'h0000, 64'h0);
    `CHK(rd64[31:0], 32'h0300_0209)
    reg_rd(HR_IDENT, rerr);
    `CHK(rerr, 8'h00)
    acc(1'b0, 1'b1, RES_POSFLT, 16'h0000, 64'h0);
    `CHK(rd64[31:0], 32'h0300_040A)
    acc(1'b0, 1'b0, RES_FACRST, 16'h0000, 64'h0);
    `CHK(rerr, ERR_NOREAD)
    // Index: boundary values, then activation only by a reset.
    acc(1'b1, 1'b0, RES_ENCIDX, 16'h0000, 64'h10);
    `CHK(rerr, ERR_RANGE)
    acc(1'b1, 1'b0, RES_ENCIDX, 16'h0000, 64'hF);
    `CHK(rerr, ERR_NONE)
    acc(1'b0, 1'b0, RES_ENCIDX, 16'h0000, 64'h0);
    `CHK(rd64[15:0], 16'h000F)
    reg_rd(HR_IDENT, rerr);
    `CHK(rerr, 8'h0F)
    `CHK(enc_index, 4'h0)
    acc(1'b1, 1'b0, RES_SWRESET, 16'h0000, 64'h0);
    `CHK(enc_index, 4'hF)
    // Extended index resource and its enable status.
    acc(1'b1, 1'b0, RES_EXTIDX, 16'h0001, 64'h10);
    `CHK(rerr, ERR_RANGE)
    acc(1'b1, 1'b0, RES_EXTIDX, 16'h0001, 64'hF);
    acc(1'b0, 1'b0, RES_EXTIDX, 16'h0001, 64'h0);
    `CHK(rd64[15:0], 16'h000F)
    acc(1'b0, 1'b0, RES_EXTIDX, 16'h0000, 64'h0);
    `CHK(rd64[15:0], 16'h000F)
    acc(1'b0, 1'b0, RES_EXTIDX, 16'h0002, 64'h0);
    `CHK(rerr, ERR_OFFSET)
    `CHK(incorp_en, 1'b0)
    // A hardware reset must bring up the stored settings.
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    `CHK(enc_index, 4'hF)
    `CHK(incorp_en, 1'b1)
    // Filter: default, then both range edges from each side.
    acc(1'b0, 1'b0, RES_POSFLT, 16'h0000, 64'h0);
    `CHK(rd64[31:0], 32'd35000)
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 1'b0, RES_POSFLT, 16'h0000, {32'h0, fv[i]});
      `CHK(rerr, (fv[i] < 32'd3000 || fv[i] > 32'd37500) ? ERR_RANGE : ERR_NONE)
    end
    acc(1'b0, 1'b0, RES_POSFLT, 16'h0000, 64'h0);
    `CHK(rd64[31:0], 32'd37500)
    // Warnings: every type and format, read back in the written layout.
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b1, 1'b0, RES_WARN, 16'(i), {48'h0, 8'hC1, 3'(i % 4 + 1), 3'(fmts[i]), 2'b00});
      acc(1'b0, 1'b0, RES_WARN, 16'(i), 64'h0);
      `CHK(rd64[15:0], {8'hC1, 3'(i % 4 + 1), 3'(fmts[i]), 2'b00})
      m = (fmts[i] % 4 == 1) ? 64'hFFFF : (fmts[i] % 4 == 2) ? 64'hFFFF_FFFF : '1;
      acc(1'b1, 1'b0, RES_WARN, 16'(16 + i), 64'h8123_4567_89AB_CDEF);
      acc(1'b0, 1'b0, RES_WARN, 16'(16 + i), 64'h0);
      `CHK(rd64 & m, 64'h8123_4567_89AB_CDEF & m)
    end
    acc(1'b1, 1'b0, RES_WARN, 16'h0020, 64'h0);
    `CHK(rerr, ERR_OFFSET)
    // Factory reset: a wrong word does nothing, each code word its own part.
    acc(1'b1, 1'b0, RES_FACRST, 16'h0000, 64'h1122_3344_5566_7788);
    `CHK(ufc_n + lc_n, 0)
    acc(1'b1, 1'b0, RES_FACRST, 16'h0000, USER_FILES_RESET_WORD);
    `CHK(ufc_n, 1)
    `CHK(lc_n, 0)
    acc(1'b1, 1'b0, RES_FACRST, 16'h0000, FULL_FACTORY_RESET_WORD);
    `CHK(lc_n, 1)
    `CHK(ufc_n, 2)
    acc(1'b0, 1'b0, RES_WARN, 16'h0000, 64'h0);
    `CHK(rd64[7:0], 8'h00)
    // The filter is written back to its factory setting, as the operator should keep it.
    acc(1'b1, 1'b0, RES_POSFLT, 16'h0000, {32'h0, FILT_DEFAULT});
    `CHK(rerr, ERR_NONE)
    // A whole second never passes in this run, so no evaluation may fire.
    `CHK(warn_event, 1'b0)
    print_verdict();
  end
endmodule
